// >>> csc_map.vh
`ifndef CSC_MAP_VH
`define CSC_MAP_VH
// register indices on the plain port
`define CSC_ADDR_FLAGS      2'h0
`define CSC_ADDR_CORE       2'h1
`define CSC_ADDR_INTCTL     2'h2
// flags register bit positions
`define CSC_F_A_SPILL       15
`define CSC_F_B_SPILL       14
`define CSC_F_A_CLIP        13
`define CSC_F_B_CLIP        12
`define CSC_F_ANY_SPILL     11
`define CSC_F_ANY_CLIP      10
`define CSC_F_HW_LOOP       9
`define CSC_F_NIB_CARRY     8
`define CSC_F_PRIO_HI       7
`define CSC_F_PRIO_LO       5
`define CSC_F_REP_LOOP      4
`define CSC_F_NEG           3
`define CSC_F_OVF           2
`define CSC_F_ZERO          1
`define CSC_F_CARRY         0
// core control bit positions
`define CSC_C_MUL_UNS       12
`define CSC_C_EARLY_EXIT    11
`define CSC_C_DEPTH_HI      10
`define CSC_C_DEPTH_LO      8
`define CSC_C_A_CLIP_EN     7
`define CSC_C_B_CLIP_EN     6
`define CSC_C_STORE_CLIP    5
`define CSC_C_CLIP_WIDTH    4
`define CSC_C_PRIO_TOP      3
`define CSC_C_PROG_WIN      2
`define CSC_C_ROUND         1
`define CSC_C_INT_MUL       0
// interrupt control one nesting disable bit
`define CSC_I_NEST_OFF      15
// reset values
`define CSC_CORE_RST        16'h0020
`define CSC_FLAGS_RST       16'h0000
// alu opcodes
`define CSC_OP_ADD          3'h0
`define CSC_OP_SUB          3'h1
`define CSC_OP_AND          3'h2
`define CSC_OP_OR           3'h3
`define CSC_OP_XOR          3'h4
`define CSC_OP_SHL          3'h5
`define CSC_OP_SHR          3'h6
`define CSC_OP_ASR          3'h7
`endif

// >>> csc_core.v
// Notes on behaviour
// (RULE1) guard spill flags A,B at 15,14, read-only
// (RULE2) clip sticky flags stay set, clear-only
// (RULE3) bit 11 is OR of spill flags
// (RULE4) bit 10 ORs clips; clearing clears both
// (RULE5) bits 9,4 show DO and REPEAT activity
// (RULE6) nibble carry from bit 4 or 8
// (RULE7) priority is top bit over bits 7-5
// (RULE8) low priority bits locked when nesting off
// (RULE9) low bits give level 0-7 or 8-15
// (RULE10) negative flag follows result sign
// (RULE11) overflow flag on signed sign change
// (RULE12) zero flag cleared only by nonzero result; code also clears it on a flags write of zero to bit 1
// (RULE13) carry flag from result top bit
// (RULE14) subtraction makes carries into borrows
// (RULE15) unsigned multiply select, resets zero
// (RULE16) early loop exit pulse, reads zero
// (RULE17) nesting depth read-only in bits 10-8
// (RULE18) clip enables; store enable resets one
// (RULE19) clip width selects 9.31 or 1.31
// (RULE20) priority top read, clear, never set
// (RULE21) program window, rounding, integer multiply
// (RULE22) alu does 8/16-bit arithmetic, logic, shifts
// (RULE23) spill flags refresh on each accumulator pass
// (RULE24) read-only bits ignore writes; 15-13 zero
//
// Our own choices: the register offsets and strobed register access.
`include "csc_map.vh"
module csc_core (
   // clock and reset
   input  wire        mclk_in,
   input  wire        rst_n_in,
   // register port
   input  wire [1:0]  addr_in,
   input  wire [15:0] wdata_in,
   input  wire        wr_in,
   input  wire        rd_in,
   output reg  [15:0] rdata_out,
   // alu request
   input  wire        alu_go_in,
   input  wire [2:0]  alu_op_in,
   input  wire        alu_byte_in,
   input  wire        alu_cin_in,
   input  wire        alu_use_cin_in,
   input  wire [15:0] alu_a_in,
   input  wire [15:0] alu_b_in,
   output reg  [15:0] alu_res_out,
   output reg         alu_done_out,
   // accumulator adder status
   input  wire        acc_pass_in,
   input  wire        acc_sel_b_in,
   input  wire        acc_spill_in,
   input  wire        acc_clip_in,
   // loop engine status and priority load
   input  wire        hw_loop_active_in,
   input  wire        rep_loop_active_in,
   input  wire [2:0]  loop_nest_depth_in,
   input  wire        prio_set_in,
   input  wire [3:0]  prio_new_in,
   // control outputs
   output wire        loop_early_exit_out,
   output wire        mul_unsigned_sel_out,
   output wire        acc_a_clip_en_out,
   output wire        acc_b_clip_en_out,
   output wire        store_clip_en_out,
   output wire        clip_width_sel_out,
   output wire        prog_window_en_out,
   output wire        round_sel_out,
   output wire        int_mul_sel_out,
   output wire [3:0]  cpu_priority_out,
   output wire        user_int_off_out
);

   reg        a_spill_reg;
   reg        b_spill_reg;
   reg        a_clip_reg;
   reg        b_clip_reg;
   reg  [2:0] prio_low_reg;
   reg        prio_top_reg;
   reg        nib_reg;
   reg        neg_reg;
   reg        ovf_reg;
   reg        zero_reg;
   reg        carry_reg;
   reg  [7:0] core_cfg_reg;
   reg        exit_reg;
   reg        nesting_off_reg;
   reg        hw_loop_s1_reg;
   reg        hw_loop_reg;
   reg        rep_s1_reg;
   reg        rep_reg;
   reg  [2:0] depth_s1_reg;
   reg  [2:0] depth_reg;

   reg  [16:0] sum_next;
   reg  [15:0] res_next;
   reg         cout_next;
   reg         nib_next;
   reg         ovf_next;
   reg         arith_next;
   reg         sh_out_next;
   reg  [15:0] bx;
   reg         cin;
   wire [15:0] flags_rd;
   wire [15:0] core_rd;
   wire        wr_flags;
   wire        wr_core;
   wire        res_neg;
   wire        res_zero;

   // core control reset image, taken field by field so the packing matches the write path
   localparam [15:0] CORE_RST = `CSC_CORE_RST;
   localparam [7:0]  CFG_RST  = {CORE_RST[`CSC_C_MUL_UNS], CORE_RST[7:4],
                                 CORE_RST[`CSC_C_PROG_WIN:`CSC_C_INT_MUL]};

   assign wr_flags = wr_in && (addr_in == `CSC_ADDR_FLAGS);
   assign wr_core  = wr_in && (addr_in == `CSC_ADDR_CORE);

   // alu datapath
   always @* begin
      bx          = alu_b_in;
      cin         = alu_use_cin_in ? alu_cin_in : 1'b0;
      arith_next  = 1'b0;
      sh_out_next = 1'b0;
      sum_next    = 17'h00000;
      res_next    = 16'h0000;
      case (alu_op_in)
         `CSC_OP_ADD, `CSC_OP_SUB: begin
            arith_next = 1'b1;
            if (alu_op_in == `CSC_OP_SUB) begin
               bx  = ~alu_b_in; // RULE14
               cin = alu_use_cin_in ? alu_cin_in : 1'b1; // RULE14
            end
            if (alu_byte_in) begin
               sum_next = {8'h00, {1'b0, alu_a_in[7:0]} + {1'b0, bx[7:0]} + {8'h00, cin}};
            end else begin
               sum_next = {1'b0, alu_a_in} + {1'b0, bx} + {16'h0000, cin}; // RULE22
            end
            res_next = sum_next[15:0];
         end
         `CSC_OP_AND: res_next = alu_a_in & alu_b_in;
         `CSC_OP_OR:  res_next = alu_a_in | alu_b_in;
         `CSC_OP_XOR: res_next = alu_a_in ^ alu_b_in;
         `CSC_OP_SHL: begin
            res_next    = {alu_a_in[14:0], 1'b0};
            sh_out_next = alu_byte_in ? alu_a_in[7] : alu_a_in[15];
         end
         `CSC_OP_SHR: begin
            res_next    = alu_byte_in ? {8'h00, 1'b0, alu_a_in[7:1]}
                                      : {1'b0, alu_a_in[15:1]};
            sh_out_next = alu_a_in[0];
         end
         `CSC_OP_ASR: begin
            res_next    = alu_byte_in ? {8'h00, alu_a_in[7], alu_a_in[7:1]}
                                      : {alu_a_in[15], alu_a_in[15:1]};
            sh_out_next = alu_a_in[0];
         end
         default: res_next = 16'h0000;
      endcase
      if (alu_byte_in) begin
         res_next  = {8'h00, res_next[7:0]}; // RULE22
         cout_next = arith_next ? sum_next[8] : sh_out_next; // RULE13
         nib_next  = alu_a_in[4] ^ bx[4] ^ res_next[4]; // RULE6
         ovf_next  = (alu_a_in[7] == bx[7]) && (res_next[7] != alu_a_in[7]); // RULE11
      end else begin
         cout_next = arith_next ? sum_next[16] : sh_out_next; // RULE13
         nib_next  = alu_a_in[8] ^ bx[8] ^ res_next[8]; // RULE6
         ovf_next  = (alu_a_in[15] == bx[15]) && (res_next[15] != alu_a_in[15]); // RULE11
      end
   end

   assign res_neg  = alu_byte_in ? res_next[7] : res_next[15];
   assign res_zero = alu_byte_in ? (res_next[7:0] == 8'h00) : (res_next == 16'h0000);

   // status and control state
   always @(posedge mclk_in) begin
      if (!rst_n_in) begin
         a_spill_reg     <= 1'b0;
         b_spill_reg     <= 1'b0;
         a_clip_reg      <= 1'b0;
         b_clip_reg      <= 1'b0;
         prio_low_reg    <= 3'h0;
         prio_top_reg    <= 1'b0;
         nib_reg         <= 1'b0;
         neg_reg         <= 1'b0;
         ovf_reg         <= 1'b0;
         zero_reg        <= 1'b0;
         carry_reg       <= 1'b0;
         core_cfg_reg    <= CFG_RST; // RULE18
         exit_reg        <= 1'b0;
         nesting_off_reg <= 1'b0;
         alu_res_out     <= 16'h0000;
         alu_done_out    <= 1'b0;
         rdata_out       <= 16'h0000;
         hw_loop_s1_reg  <= 1'b0;
         hw_loop_reg     <= 1'b0;
         rep_s1_reg      <= 1'b0;
         rep_reg         <= 1'b0;
         depth_s1_reg    <= 3'h0;
         depth_reg       <= 3'h0;
      end else begin
         hw_loop_s1_reg <= hw_loop_active_in;
         hw_loop_reg    <= hw_loop_s1_reg;
         rep_s1_reg     <= rep_loop_active_in;
         rep_reg        <= rep_s1_reg;
         depth_s1_reg   <= loop_nest_depth_in;
         depth_reg      <= depth_s1_reg;
         alu_done_out   <= alu_go_in;
         // software writes first, hardware events override
         if (wr_flags) begin
            if (!wdata_in[`CSC_F_A_CLIP] || !wdata_in[`CSC_F_ANY_CLIP])
               a_clip_reg <= 1'b0; // RULE2 RULE4
            if (!wdata_in[`CSC_F_B_CLIP] || !wdata_in[`CSC_F_ANY_CLIP])
               b_clip_reg <= 1'b0; // RULE2 RULE4
            if (!nesting_off_reg)
               prio_low_reg <= wdata_in[`CSC_F_PRIO_HI:`CSC_F_PRIO_LO]; // RULE8
            nib_reg   <= wdata_in[`CSC_F_NIB_CARRY];
            neg_reg   <= wdata_in[`CSC_F_NEG];
            ovf_reg   <= wdata_in[`CSC_F_OVF];
            zero_reg  <= wdata_in[`CSC_F_ZERO];
            carry_reg <= wdata_in[`CSC_F_CARRY];
         end
         if (wr_core) begin
            core_cfg_reg <= {wdata_in[`CSC_C_MUL_UNS], wdata_in[7:4],
                             wdata_in[`CSC_C_PROG_WIN:`CSC_C_INT_MUL]}; // RULE15 RULE18 RULE19 RULE21
            if (!wdata_in[`CSC_C_PRIO_TOP])
               prio_top_reg <= 1'b0; // RULE20
         end
         exit_reg <= wr_core && wdata_in[`CSC_C_EARLY_EXIT]; // RULE16
         if (wr_in && addr_in == `CSC_ADDR_INTCTL)
            nesting_off_reg <= wdata_in[`CSC_I_NEST_OFF];
         if (prio_set_in) begin
            prio_top_reg <= prio_new_in[3]; // RULE7
            prio_low_reg <= prio_new_in[2:0]; // RULE9
         end
         if (acc_pass_in) begin
            if (acc_sel_b_in) begin
               b_spill_reg <= acc_spill_in; // RULE23 RULE1
               if (acc_clip_in) b_clip_reg <= 1'b1; // RULE2
            end else begin
               a_spill_reg <= acc_spill_in; // RULE23 RULE1
               if (acc_clip_in) a_clip_reg <= 1'b1; // RULE2
            end
         end
         if (alu_go_in) begin
            alu_res_out <= res_next;
            neg_reg     <= res_neg; // RULE10
            if (arith_next) begin
               ovf_reg <= ovf_next; // RULE11
               nib_reg <= nib_next; // RULE6 RULE14
            end
            if (arith_next || alu_op_in == `CSC_OP_SHL || alu_op_in == `CSC_OP_SHR ||
                alu_op_in == `CSC_OP_ASR)
               carry_reg <= cout_next; // RULE13 RULE14
            if (res_zero) zero_reg <= 1'b1; // RULE12
            else          zero_reg <= 1'b0; // RULE12
         end
         case (addr_in)
            `CSC_ADDR_FLAGS:  rdata_out <= rd_in ? flags_rd : 16'h0000;
            `CSC_ADDR_CORE:   rdata_out <= rd_in ? core_rd : 16'h0000;
            `CSC_ADDR_INTCTL: rdata_out <= rd_in ? {nesting_off_reg, 15'h0000} : 16'h0000;
            default:          rdata_out <= 16'h0000;
         endcase
      end
   end

   assign flags_rd = {a_spill_reg, b_spill_reg, a_clip_reg, b_clip_reg,
                      a_spill_reg | b_spill_reg, // RULE3
                      a_clip_reg | b_clip_reg, // RULE4
                      hw_loop_reg, nib_reg, prio_low_reg, // RULE5
                      rep_reg, neg_reg, ovf_reg, zero_reg, carry_reg}; // RULE5
   assign core_rd  = {3'h0, core_cfg_reg[7], 1'b0, depth_reg, // RULE24 RULE16 RULE17
                      core_cfg_reg[6:3], prio_top_reg, core_cfg_reg[2:0]};

   assign loop_early_exit_out  = exit_reg; // RULE16
   assign mul_unsigned_sel_out = core_cfg_reg[7]; // RULE15
   assign acc_a_clip_en_out    = core_cfg_reg[6]; // RULE18
   assign acc_b_clip_en_out    = core_cfg_reg[5]; // RULE18
   assign store_clip_en_out    = core_cfg_reg[4]; // RULE18
   assign clip_width_sel_out   = core_cfg_reg[3]; // RULE19
   assign prog_window_en_out   = core_cfg_reg[2]; // RULE21
   assign round_sel_out        = core_cfg_reg[1]; // RULE21
   assign int_mul_sel_out      = core_cfg_reg[0]; // RULE21
   assign cpu_priority_out     = {prio_top_reg, prio_low_reg}; // RULE7 RULE9
   assign user_int_off_out     = prio_top_reg || (prio_low_reg == 3'h7); // RULE7 RULE9

endmodule // csc_core

// >>> csc_core_asserts.sv
module csc_core_asserts (
   // clock and reset
   input logic        mclk_in,
   input logic        rst_n_in,
   // register port
   input logic [1:0]  addr_in,
   input logic [15:0] wdata_in,
   input logic        wr_in,
   input logic        rd_in,
   input logic [15:0] rdata_out,
   // alu
   input logic        alu_go_in,
   input logic        alu_byte_in,
   input logic [15:0] alu_res_out,
   input logic        alu_done_out,
   // priority and control
   input logic        prio_set_in,
   input logic [3:0]  prio_new_in,
   input logic        loop_early_exit_out,
   input logic        mul_unsigned_sel_out,
   input logic        store_clip_en_out,
   input logic [3:0]  cpu_priority_out,
   input logic        user_int_off_out
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!rst_n_in);
   sequence s_cwr;
      wr_in && addr_in == 2'h1;
   endsequence
   sequence s_exit_wr;
      s_cwr ##0 wdata_in[11];
   endsequence
   sequence s_frd;
      rd_in && addr_in == 2'h0;
   endsequence
   a_done_pulse: assert property (alu_go_in |=> alu_done_out)
      else $error("alu done missing");
   a_done_only: assert property (!alu_go_in |=> !alu_done_out)
      else $error("alu done without request");
   a_byte_high: assert property (alu_go_in && alu_byte_in |=> alu_res_out[15:8] == 8'h00)
      else $error("byte result high byte not zero");
   a_exit_pulse: assert property (s_exit_wr |=> loop_early_exit_out)
      else $error("early exit pulse missing");
   a_exit_only: assert property (!(wr_in && addr_in == 2'h1 && wdata_in[11])
      |=> !loop_early_exit_out)
      else $error("early exit pulse without write");
   a_rdata_idle: assert property (!rd_in |=> rdata_out == 16'h0000)
      else $error("read data outside read");
   a_flag_ors: assert property (s_frd |=> rdata_out[11] == (rdata_out[15] | rdata_out[14])
      && rdata_out[10] == (rdata_out[13] | rdata_out[12]))
      else $error("combined flag bits wrong");
   a_prio_load: assert property (prio_set_in |=> cpu_priority_out == $past(prio_new_in))
      else $error("priority load wrong");
   a_user_off: assert property (user_int_off_out == (cpu_priority_out[3]
      || cpu_priority_out[2:0] == 3'h7))
      else $error("user interrupt disable wrong");
   a_cfg_write: assert property (s_cwr |=> mul_unsigned_sel_out == $past(wdata_in[12]))
      else $error("unsigned select not written");
   a_cfg_hold: assert property (!(wr_in && addr_in == 2'h1)
      |=> $stable(mul_unsigned_sel_out) && $stable(store_clip_en_out))
      else $error("config changed without write");
endmodule // csc_core_asserts

bind csc_core csc_core_asserts u_chk (
   .mclk_in(mclk_in), .rst_n_in(rst_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
   .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .alu_go_in(alu_go_in),
   .alu_byte_in(alu_byte_in), .alu_res_out(alu_res_out), .alu_done_out(alu_done_out),
   .prio_set_in(prio_set_in), .prio_new_in(prio_new_in),
   .loop_early_exit_out(loop_early_exit_out), .mul_unsigned_sel_out(mul_unsigned_sel_out),
   .store_clip_en_out(store_clip_en_out), .cpu_priority_out(cpu_priority_out),
   .user_int_off_out(user_int_off_out)
);

// >>> csc_core_tb.sv
module csc_core_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 0, rst_n = 0, wr = 0, rd = 0, go = 0, byt = 0, pset = 0;
   logic        pass = 0, selb = 0, spill = 0, clip = 0, hwl = 0, repl = 0;
   logic [1:0]  addr = 0;
   logic [2:0]  op = 0, dep = 0;
   logic [3:0]  pnew = 0, pri;
   logic [15:0] wd = 0, a = 0, b = 0, rdata, res;
   logic        done, ext, mus, acl, bcl, scl, cw, pw, rs, im, uoff;
   logic [87:0] e;
   int          err_count = 0, num_checks = 0;
   // op, byte, a, b, result, flag mask, flags
   logic [87:0] tbl [12] = '{
      88'h0_0_7FFF_0001_8000_010F_010C, 88'h0_0_FFFF_0001_0000_010F_0103,
      88'h1_0_0005_0005_0000_010F_0103, 88'h1_0_0000_0001_FFFF_010F_0008,
      88'h0_1_000F_0001_0010_010F_0100, 88'h0_1_0080_0080_0000_010F_0007,
      88'h2_0_F0F0_0F0F_0000_010F_0007, 88'h3_0_1200_0034_1234_000A_0000,
      88'h4_0_FFFF_00FF_FF00_000A_0008, 88'h5_0_4001_0001_8002_0009_0008,
      88'h6_0_8000_0004_4000_0009_0000, 88'h7_0_8000_0004_C000_0009_0008};
   csc_core dut (
      .mclk_in(clk), .rst_n_in(rst_n), .addr_in(addr), .wdata_in(wd), .wr_in(wr),
      .rd_in(rd), .rdata_out(rdata), .alu_go_in(go), .alu_op_in(op), .alu_byte_in(byt),
      .alu_cin_in(1'b0), .alu_use_cin_in(1'b0), .alu_a_in(a), .alu_b_in(b),
      .alu_res_out(res), .alu_done_out(done), .acc_pass_in(pass), .acc_sel_b_in(selb),
      .acc_spill_in(spill), .acc_clip_in(clip), .hw_loop_active_in(hwl),
      .rep_loop_active_in(repl), .loop_nest_depth_in(dep), .prio_set_in(pset),
      .prio_new_in(pnew), .loop_early_exit_out(ext), .mul_unsigned_sel_out(mus),
      .acc_a_clip_en_out(acl), .acc_b_clip_en_out(bcl), .store_clip_en_out(scl),
      .clip_width_sel_out(cw), .prog_window_en_out(pw), .round_sel_out(rs),
      .int_mul_sel_out(im), .cpu_priority_out(pri), .user_int_off_out(uoff));
   initial begin
      forever #2.5 clk = ~clk;
   end
   task chk(input logic [15:0] s, input logic [15:0] x);
      num_checks++;
      if (s !== x) begin
         err_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, s, x);
      end
   endtask
   task wrr(input logic [1:0] ad, input logic [15:0] d);
      @(posedge clk);
      wr <= 1;
      addr <= ad;
      wd <= d;
      @(posedge clk);
      wr <= 0;
   endtask
   task rdc(input logic [1:0] ad, input logic [15:0] m, input logic [15:0] x);
      @(posedge clk);
      rd <= 1;
      addr <= ad;
      @(posedge clk);
      rd <= 0;
      #1 chk(rdata & m, x);
   endtask
   task acc(input logic sb, input logic sp, input logic cl);
      @(posedge clk);
      pass <= 1;
      selb <= sb;
      spill <= sp;
      clip <= cl;
      @(posedge clk);
      pass <= 0;
   endtask
   task alu(input logic [3:0] o, input logic [3:0] bb, input logic [15:0] x, y, r);
      @(posedge clk);
      go <= 1;
      op <= o[2:0];
      byt <= bb[0];
      a <= x;
      b <= y;
      @(posedge clk);
      go <= 0;
      #1 chk({15'h0000, done}, 16'h0001);
      chk(res, r);
   endtask
   task summarize;
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   initial begin
      #50000;
      err_count++;
      summarize();
   end
   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1;
      rdc(2'h0, 16'hFFFF, 16'h0000);
      rdc(2'h1, 16'hFFFF, 16'h0020);
      $display("test reset done");
      wrr(2'h1, 16'hFFFF);
      #1 chk({15'h0000, ext}, 16'h0001);
      chk({8'h00, mus, acl, bcl, scl, cw, pw, rs, im}, 16'h00FF);
      rdc(2'h1, 16'hFFFF, 16'h10F7);
      wrr(2'h1, 16'h0000);
      rdc(2'h1, 16'hFFFF, 16'h0000);
      $display("test core done");
      @(posedge clk);
      hwl <= 1;
      repl <= 1;
      dep <= 3'h7;
      repeat (3) @(posedge clk);
      wrr(2'h0, 16'h0000);
      rdc(2'h0, 16'h0210, 16'h0210);
      rdc(2'h1, 16'h0700, 16'h0700);
      hwl <= 0;
      repl <= 0;
      repeat (3) @(posedge clk);
      rdc(2'h0, 16'h0210, 16'h0000);
      $display("test loops done");
      acc(0, 1, 1);
      rdc(2'h0, 16'hFC00, 16'hAC00);
      acc(1, 1, 1);
      rdc(2'h0, 16'hFC00, 16'hFC00);
      acc(0, 0, 0);
      rdc(2'h0, 16'hFC00, 16'h7C00);
      acc(1, 0, 0);
      wrr(2'h0, 16'h3400);
      rdc(2'h0, 16'hFC00, 16'h3400);
      wrr(2'h0, 16'h3000);
      rdc(2'h0, 16'hFC00, 16'h0000);
      wrr(2'h0, 16'hFC00);
      rdc(2'h0, 16'hFC00, 16'h0000);
      $display("test accumulators done");
      wrr(2'h0, 16'h00E0);
      #1 chk({11'h000, uoff, pri}, 16'h0017);
      wrr(2'h0, 16'h0060);
      #1 chk({11'h000, uoff, pri}, 16'h0003);
      @(posedge clk);
      pset <= 1;
      pnew <= 4'hA;
      @(posedge clk);
      pset <= 0;
      #1 chk({11'h000, uoff, pri}, 16'h001A);
      rdc(2'h1, 16'h0008, 16'h0008);
      rdc(2'h0, 16'h00E0, 16'h0040);
      wrr(2'h1, 16'h0000);
      #1 chk({11'h000, uoff, pri}, 16'h0002);
      wrr(2'h1, 16'h0008);
      rdc(2'h1, 16'h0008, 16'h0000);
      wrr(2'h2, 16'h8000);
      wrr(2'h0, 16'h00A0);
      rdc(2'h0, 16'h00E0, 16'h0040);
      wrr(2'h2, 16'h0000);
      wrr(2'h0, 16'h00A0);
      rdc(2'h0, 16'h00E0, 16'h00A0);
      rdc(2'h3, 16'hFFFF, 16'h0000);
      $display("test priority done");
      @(posedge clk);
      rst_n <= 0;
      @(posedge clk);
      rst_n <= 1;
      rdc(2'h1, 16'hFFFF, 16'h0020);
      rdc(2'h0, 16'hFFFF, 16'h0000);
      #1 chk({11'h000, uoff, pri}, 16'h0000);
      $display("test reset again done");
      for (int i = 0; i < 12; i++) begin
         e = tbl[i];
         alu(e[87:84], e[83:80], e[79:64], e[63:48], e[47:32]);
         rdc(2'h0, e[31:16], e[15:0]);
      end
      $display("test alu done");
      summarize();
   end
endmodule // csc_core_tb
